// [design/tlbp_pkg.sv]
package tlbp_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int PA_W      = 32;
  localparam int PFN_W     = PA_W - 12;
  localparam int ADDRESS_SPACE_ID_W    = 8;
  localparam int VIRTUAL_PAGE_PAIR_NUMBER_W    = 21;
  localparam int MASK_W    = 14;
  localparam int NENT_DEF  = 8;
  localparam int EO_BASE   = 10;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_HIGH   = 8'h00;
  localparam logic [7:0] OFS_EVEN   = 8'h04;
  localparam logic [7:0] OFS_ODD    = 8'h08;
  localparam logic [7:0] OFS_PSIZE  = 8'h0c;
  localparam logic [7:0] OFS_GRAIN  = 8'h10;
  localparam logic [7:0] OFS_LAYOUT = 8'h14;
  localparam logic [7:0] OFS_PTRREG = 8'h18;
  localparam logic [7:0] OFS_FAULT  = 8'h1c;
  localparam logic [7:0] OFS_CTRL   = 8'h20;
  localparam logic [7:0] OFS_WRIDX  = 8'h24;
  localparam logic [7:0] OFS_ISTAT  = 8'h28;
  localparam logic [7:0] OFS_IMASK  = 8'h2c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int F_RB    = 31;
  localparam int F_FB    = 30;
  localparam int F_PFN   = 6;
  localparam int F_C     = 3;
  localparam int F_D     = 2;
  localparam int F_V     = 1;
  localparam int F_G     = 0;
  localparam int F_VIRTUAL_PAGE_PAIR_NUMBER  = 11;
  localparam int F_PSIZE = 11;
  localparam int F_WR    = 31;
  localparam int EV_REFILL = 0;
  localparam int EV_INVAL  = 1;
  localparam int EV_MODIF  = 2;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    TLBP_FETCH = 3'b001,
    TLBP_LOAD  = 3'b010,
    TLBP_STORE = 3'b100
  } tlbp_ref_t;

  typedef struct packed {
    logic             rb;
    logic             fb;
    logic [PFN_W-1:0] pfn;
    logic [2:0]       c;
    logic             d;
    logic             v;
  } tlbp_half_t;

  typedef struct packed {
    logic [MASK_W-1:0] mask;
    logic [VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] virtual_page_pair_number;
    logic              g;
    logic [ADDRESS_SPACE_ID_W-1:0] address_space_id;
    tlbp_half_t        even;
    tlbp_half_t        odd;
  } tlbp_entry_t;

  typedef struct packed {
    logic       valid;
    logic [31:0] va;
    tlbp_ref_t  reftype;
    logic       pc_rel;
  } tlbp_req_t;

  typedef struct packed {
    logic            valid;
    logic [PA_W-1:0] pa;
    logic            hit;
    logic [2:0]      cache;
    logic            miss;
    logic            refill;
    logic            invalid;
    logic            modified;
  } tlbp_rsp_t;

endpackage

// [design/tlbp_entry_cmp.sv]
module tlbp_entry_cmp
  import tlbp_pkg::*;
(
  // Entry and reference
  input  wire tlbp_pkg::tlbp_entry_t ent_i,
  input  wire logic [31:0]           va_i,
  input  wire logic [ADDRESS_SPACE_ID_W-1:0]     address_space_id_i,
  input  wire logic [1:0]            grain_i,
  // Result
  output logic                       match_o,
  output logic [4:0]                 eo_bit_o,
  output tlbp_pkg::tlbp_half_t       half_o
);
  import tlbp_pkg::*;

  logic [MASK_W-1:0] eff_mask;
  logic [VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] cmp_mask;
  logic [4:0]        ones;

  // R3: effective mask
  assign eff_mask = ent_i.mask | {{(MASK_W-2){1'b0}}, grain_i};
  assign cmp_mask = ~{{(VIRTUAL_PAGE_PAIR_NUMBER_W-MASK_W){1'b0}}, eff_mask};

  // R3: pair select position
  always_comb
  begin
    ones = 5'h00;
    for (int i = 0; i < MASK_W; i++)
    begin
      ones = ones + {4'h0, eff_mask[i]};
    end
  end
  assign eo_bit_o = 5'(EO_BASE) + ones;

  // R1: tag and space match
  assign match_o = ((ent_i.virtual_page_pair_number & cmp_mask) == (va_i[31:11] & cmp_mask))
                   && (ent_i.g || (ent_i.address_space_id == address_space_id_i));

  // R4: even or odd half
  assign half_o = va_i[eo_bit_o] ? ent_i.odd : ent_i.even;

endmodule // tlbp_entry_cmp

// [design/tlbp_top.sv]
// Operation
// R1: Match on masked pair number and space
// R2: Entry maps even/odd pages from two registers
// R3: Mask OR grain gives pair-select bit
// R4: Pair-select bit picks even or odd half
// R5: Clear valid bit raises invalid
// R6: Load on read-blocked half raises invalid
// R7: PC-relative load allowed when fetch permitted
// R8: Fetch on fetch-blocked half raises invalid
// R9: Store without write permit raises modified
// R10: Frame number aligned by granularity mask
// R11: Address is frame bits plus offset
// R12: All mask combinations translate identically
// R13: No match with level clear: refill
// R14: Refill records faulting address
// R15: Refill loads pointer bits from address
// R16: Refill loads high register address bits
// R17: Refill loads missing space identifier
module tlbp_top
  import tlbp_pkg::*;
#(
  parameter int NENT = NENT_DEF
)
(
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                resetn_i,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Lookup port
  input  wire tlbp_pkg::tlbp_req_t req_i,
  output tlbp_pkg::tlbp_rsp_t      rsp_o,
  // Interrupt
  output logic                     irq_o
);
  import tlbp_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] high_r, even_r, odd_r, psize_r, grain_r;
  logic [31:0] layout_r, ptr_r, fault_r, ctrl_r, wridx_r;
  logic [2:0]  istat_r, imask_r;
  logic [31:0] high_nxt, ptr_nxt, fault_nxt, wr_data, rd_data;
  logic [2:0]  istat_nxt;
  logic        ack_r, irq_r;
  tlbp_rsp_t   rsp_r, rsp_nxt;
  tlbp_entry_t tlb_r [NENT];
  tlbp_entry_t new_ent;

  // ****************************************
  // Bus decode
  // ****************************************
  wire         bus_req  = wb_cyc_i && wb_stb_i && !ack_r;
  wire         bus_wr   = bus_req && wb_we_i;
  wire         bus_rd   = bus_req && !wb_we_i;
  wire [31:0]  sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire         wr_high  = bus_wr && (wb_adr_i == OFS_HIGH);
  wire         wr_even  = bus_wr && (wb_adr_i == OFS_EVEN);
  wire         wr_odd   = bus_wr && (wb_adr_i == OFS_ODD);
  wire         wr_psize = bus_wr && (wb_adr_i == OFS_PSIZE);
  wire         wr_grain = bus_wr && (wb_adr_i == OFS_GRAIN);
  wire         wr_lay   = bus_wr && (wb_adr_i == OFS_LAYOUT);
  wire         wr_ptr   = bus_wr && (wb_adr_i == OFS_PTRREG);
  wire         wr_fault = bus_wr && (wb_adr_i == OFS_FAULT);
  wire         wr_ctrl  = bus_wr && (wb_adr_i == OFS_CTRL);
  wire         wr_idx   = bus_wr && (wb_adr_i == OFS_WRIDX);
  wire         wr_imask = bus_wr && (wb_adr_i == OFS_IMASK);
  wire         rd_istat = bus_rd && (wb_adr_i == OFS_ISTAT);
  wire         ent_wr   = wr_idx && wr_data[F_WR];

  function automatic logic [31:0] merge(input logic [31:0] old);
    return (old & ~sel_mask) | (wb_dat_i & sel_mask);
  endfunction

  assign wr_data = merge(wridx_r);

  // ****************************************
  // Read mux
  // ****************************************
  always_comb
  begin
    case (wb_adr_i)
      OFS_HIGH:   rd_data = high_r;
      OFS_EVEN:   rd_data = even_r;
      OFS_ODD:    rd_data = odd_r;
      OFS_PSIZE:  rd_data = psize_r;
      OFS_GRAIN:  rd_data = grain_r;
      OFS_LAYOUT: rd_data = layout_r;
      OFS_PTRREG: rd_data = ptr_r;
      OFS_FAULT:  rd_data = fault_r;
      OFS_CTRL:   rd_data = ctrl_r;
      OFS_WRIDX:  rd_data = wridx_r;
      OFS_ISTAT:  rd_data = {29'h0, istat_r};
      OFS_IMASK:  rd_data = {29'h0, imask_r};
      default:    rd_data = RST_ZERO;
    endcase
  end

  // ****************************************
  // Entry staging
  // ****************************************
  wire [ADDRESS_SPACE_ID_W-1:0] cur_address_space_id = high_r[ADDRESS_SPACE_ID_W-1:0];
  wire [1:0]        grain    = grain_r[1:0];
  wire              exception_level_flag      = ctrl_r[0];

  function automatic tlbp_half_t half_of(input logic [31:0] lo);
    tlbp_half_t h;
    h.rb  = lo[F_RB];
    h.fb  = lo[F_FB];
    h.pfn = lo[F_PFN +: PFN_W];
    h.c   = lo[F_C +: 3];
    h.d   = lo[F_D];
    h.v   = lo[F_V];
    return h;
  endfunction

  // R2: even from even reg, odd from odd reg
  always_comb
  begin
    new_ent.mask = psize_r[F_PSIZE +: MASK_W];
    new_ent.virtual_page_pair_number = high_r[F_VIRTUAL_PAGE_PAIR_NUMBER +: VIRTUAL_PAGE_PAIR_NUMBER_W];
    new_ent.g    = even_r[F_G] & odd_r[F_G];
    new_ent.address_space_id = cur_address_space_id;
    new_ent.even = half_of(even_r);
    new_ent.odd  = half_of(odd_r);
  end

  // ****************************************
  // Lookup
  // ****************************************
  logic [NENT-1:0] ent_match;
  logic [4:0]      ent_eo   [NENT];
  tlbp_half_t      ent_half [NENT];

  for (genvar g = 0; g < NENT; g++)
  begin : g_cmp
    tlbp_entry_cmp u_cmp (
      .ent_i    (tlb_r[g]),
      .va_i     (req_i.va),
      .address_space_id_i   (cur_address_space_id),
      .grain_i  (grain),
      .match_o  (ent_match[g]),
      .eo_bit_o (ent_eo[g]),
      .half_o   (ent_half[g])
    );
  end

  logic              found;
  logic [4:0]        eo;
  tlbp_half_t        sel;
  logic [PA_W-1:0]   pa_pfn_ext;
  logic [PA_W-1:0]   low_mask;
  logic [PFN_W+1:0]  pa_pfn;

  // R1: first matching entry wins
  always_comb
  begin
    found = 1'b0;
    eo    = 5'h00;
    sel   = '0;
    for (int i = NENT - 1; i >= 0; i--)
    begin
      if (ent_match[i])
      begin
        found = 1'b1;
        eo    = ent_eo[i];
        sel   = ent_half[i];
      end
    end
  end

  // R10: align frame by granularity
  always_comb
  begin
    case (grain)
      2'b00:   pa_pfn = {2'b00, sel.pfn};
      2'b01:   pa_pfn = {1'b0, sel.pfn, 1'b0};
      2'b11:   pa_pfn = {sel.pfn, 2'b00};
      default: pa_pfn = {2'b00, sel.pfn};
    endcase
  end

  // R11: frame bits above, offset below
  assign pa_pfn_ext = {pa_pfn, 10'h000};
  assign low_mask   = (PA_W'(1) << eo) - PA_W'(1);

  wire is_load  = req_i.reftype == TLBP_LOAD;
  wire is_fetch = req_i.reftype == TLBP_FETCH;
  wire is_store = req_i.reftype == TLBP_STORE;
  // R5: valid bit
  wire inv_v  = !sel.v;
  // R6: read-block on load; R7: pc-relative exemption
  wire inv_rb = sel.rb && is_load && !(!sel.fb && req_i.pc_rel);
  // R8: fetch-block on fetch
  wire inv_fb = sel.fb && is_fetch;
  wire hit_inv = found && (inv_v || inv_rb || inv_fb);
  // R9: store without write permit
  wire hit_mod = found && !hit_inv && !sel.d && is_store;
  // R13: refill only with level clear
  wire do_refill = req_i.valid && !found && !exception_level_flag;

  always_comb
  begin
    rsp_nxt          = '0;
    rsp_nxt.valid    = req_i.valid;
    rsp_nxt.hit      = req_i.valid && found;
    // R12: one formula for all mask pairs
    rsp_nxt.pa       = (pa_pfn_ext & ~low_mask) | (req_i.va[PA_W-1:0] & low_mask);
    rsp_nxt.cache    = sel.c;
    rsp_nxt.miss     = req_i.valid && !found;
    rsp_nxt.refill   = do_refill;
    rsp_nxt.invalid  = req_i.valid && hit_inv;
    rsp_nxt.modified = req_i.valid && hit_mod;
  end

  // ****************************************
  // Refill state capture
  // ****************************************
  // R14: faulting address
  assign fault_nxt = do_refill ? req_i.va
                   : (wr_fault ? merge(fault_r) : fault_r);

  // R16: address bits; R17: space identifier
  assign high_nxt = do_refill
    ? {req_i.va[31:13], req_i.va[12:11] & ~grain, 3'h0, cur_address_space_id}
    : (wr_high ? merge(high_r) : high_r);

  // R15: scatter high va bits into pointer
  logic [31:0] ptr_fill;
  logic [5:0]  pos;
  always_comb
  begin
    pos = 6'h20;
    for (int i = 0; i < 32; i++)
    begin
      pos = pos - {5'h00, layout_r[i]};
    end
    ptr_fill = ptr_r;
    for (int i = 0; i < 32; i++)
    begin
      if (layout_r[i])
      begin
        ptr_fill[i] = req_i.va[pos[4:0]];
        pos         = pos + 6'h01;
      end
    end
  end
  assign ptr_nxt = do_refill ? ptr_fill : (wr_ptr ? merge(ptr_r) : ptr_r);

  // ****************************************
  // Interrupt status
  // ****************************************
  wire [2:0] ev = {rsp_nxt.modified, rsp_nxt.invalid, do_refill};
  assign istat_nxt = (rd_istat ? 3'h0 : istat_r) | ev;
  // Mask write through byte lanes
  wire [31:0] imask_wr  = merge({29'h0, imask_r});
  wire [2:0]  imask_nxt = wr_imask ? imask_wr[2:0] : imask_r;

  // ****************************************
  // Flops
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      high_r   <= RST_ZERO;
      even_r   <= RST_ZERO;
      odd_r    <= RST_ZERO;
      psize_r  <= RST_ZERO;
      grain_r  <= RST_ZERO;
      layout_r <= RST_ZERO;
      ptr_r    <= RST_ZERO;
      fault_r  <= RST_ZERO;
      ctrl_r   <= RST_ZERO;
      wridx_r  <= RST_ZERO;
    end
    else
    begin
      high_r   <= high_nxt;
      ptr_r    <= ptr_nxt;
      fault_r  <= fault_nxt;
      even_r   <= wr_even  ? merge(even_r)  : even_r;
      odd_r    <= wr_odd   ? merge(odd_r)   : odd_r;
      psize_r  <= wr_psize ? merge(psize_r) : psize_r;
      grain_r  <= wr_grain ? merge(grain_r) : grain_r;
      layout_r <= wr_lay   ? merge(layout_r) : layout_r;
      ctrl_r   <= wr_ctrl  ? merge(ctrl_r)  : ctrl_r;
      wridx_r  <= wr_idx   ? {1'b0, wr_data[30:0]} : wridx_r;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ack_r    <= 1'b0;
      wb_dat_o <= RST_ZERO;
      istat_r  <= 3'h0;
      imask_r  <= 3'h0;
      irq_r    <= 1'b0;
      rsp_r    <= '0;
    end
    else
    begin
      ack_r    <= bus_req;
      wb_dat_o <= bus_rd ? rd_data : RST_ZERO;
      istat_r  <= istat_nxt;
      imask_r  <= imask_nxt;
      irq_r    <= |(istat_nxt & imask_nxt);
      rsp_r    <= rsp_nxt;
    end
  end

  // R2: entry write from staging registers
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < NENT; i++)
      begin
        tlb_r[i] <= '0;
      end
    end
    else if (ent_wr)
    begin
      tlb_r[wr_data[$clog2(NENT)-1:0]] <= new_ent;
    end
  end

  assign wb_ack_o = ack_r;
  assign rsp_o    = rsp_r;
  assign irq_o    = irq_r;

endmodule // tlbp_top

// [verification/tlbp_asserts.sv]
module tlbp_asserts
  import tlbp_pkg::*;
(
  // Clock and reset
  input wire logic                clk_sys_i,
  input wire logic                resetn_i,
  // Bus and lookup
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire tlbp_pkg::tlbp_req_t req_i,
  input wire tlbp_pkg::tlbp_rsp_t rsp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import tlbp_pkg::*;

  // ****************************************
  // Lookup and bus checks
  // ****************************************
  logic [9:0] ofs_r;
  tlbp_ref_t  rt_r;

  always_ff @(posedge clk_sys_i)
  begin
    ofs_r <= req_i.va[9:0];
    rt_r  <= req_i.reftype;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence look_s;
    req_i.valid ##1 rsp_o.valid;
  endsequence

  sequence fetch_s;
    req_i.valid && req_i.reftype == TLBP_FETCH ##1 rsp_o.valid;
  endsequence

  rsp_pipe_a:
    assert property (req_i.valid |=> rsp_o.valid) else $error("lookup unanswered");
  rsp_idle_a:
    assert property (!req_i.valid |=> !rsp_o.valid) else $error("answer without lookup");
  hit_miss_a:
    assert property (rsp_o.valid |-> rsp_o.hit != rsp_o.miss) else $error("hit and miss clash");
  refill_miss_a:
    assert property (rsp_o.refill |-> rsp_o.valid && rsp_o.miss) else $error("refill on hit");
  fetch_nomod_a:
    assert property (fetch_s |-> !rsp_o.modified) else $error("modified on fetch");
  mod_store_a:
    assert property (rsp_o.modified |-> rt_r == TLBP_STORE) else $error("modified not store");
  inv_prio_a:
    assert property (rsp_o.invalid |-> !rsp_o.modified && !rsp_o.miss) else $error("bad invalid");
  offset_a:
    assert property (look_s ##0 (rsp_o.hit && !rsp_o.invalid) |-> rsp_o.pa[9:0] == ofs_r)
      else $error("page offset changed");
  ack_next_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  dat_zero_a:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
endmodule // tlbp_asserts

bind tlbp_top tlbp_asserts tlbp_asserts_i (
  .clk_sys_i (clk_sys_i),
  .resetn_i  (resetn_i),
  .wb_cyc_i  (wb_cyc_i),
  .wb_stb_i  (wb_stb_i),
  .wb_dat_o  (wb_dat_o),
  .wb_ack_o  (wb_ack_o),
  .req_i     (req_i),
  .rsp_o     (rsp_o)
);

// [verification/tlbp_pipe_model.sv]
module tlbp_pipe_model
  import tlbp_pkg::*;
(
  // Clock
  input  wire logic                clk_sys_i,
  // Lookup port
  output tlbp_pkg::tlbp_req_t      req_o,
  input  wire tlbp_pkg::tlbp_rsp_t rsp_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Pipeline request issue
  // ****************************************
  initial req_o = '0;

  task automatic lookup(input logic [31:0] va, input tlbp_ref_t rt, input logic pcr,
                        output tlbp_rsp_t rsp);
    @(posedge clk_sys_i);
    req_o <= '{1'b1, va, rt, pcr};
    @(posedge clk_sys_i);
    // Released address and pc-relative lines show the inverse; reftype is held
    req_o <= '{1'b0, ~va, rt, ~pcr};
    @(posedge clk_sys_i);
    rsp = rsp_i;
  endtask
endmodule // tlbp_pipe_model

// [verification/tlb_translation_protection_tb.sv]
module tlb_translation_protection_tb
  import tlbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Bench
  // ****************************************
  logic        clk_sys_i, resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  tlbp_req_t   req_i;
  tlbp_rsp_t   rsp_o, rs;
  int          fails, tests_run;
  logic [31:0] va0, va1, va2;
  logic [1:0]  gl [3];

  tlbp_top tlbp_top_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_i(req_i),
    .rsp_o(rsp_o), .irq_o(irq_o));
  tlbp_pipe_model tlbp_pipe_model_i (.clk_sys_i(clk_sys_i), .req_o(req_i), .rsp_i(rsp_o));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1)
    begin
      fails++;
      test_done();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  function automatic logic [31:0] lo(input logic rb, fb, input logic [19:0] pfn,
                                     input logic [2:0] c, input logic d, v);
    return {rb, fb, 4'h0, pfn, c, d, v, 1'b0};
  endfunction

  function automatic logic [31:0] pa_of(input logic [19:0] pfn, input logic [1:0] g,
                                        input int eo, input logic [31:0] va);
    logic [21:0] pp;
    logic [31:0] lm;
    pp = (g == 2'b00) ? {2'b00, pfn} : (g == 2'b01) ? {1'b0, pfn, 1'b0} : {pfn, 2'b00};
    lm = (32'h1 << eo) - 32'h1;
    return ({pp, 10'h0} & ~lm) | (va & lm);
  endfunction

  task automatic put(input logic [2:0] i, input logic [31:0] hi, ev, od, msk);
    wb(1'b1, OFS_HIGH, hi);
    wb(1'b1, OFS_EVEN, ev);
    wb(1'b1, OFS_ODD, od);
    wb(1'b1, OFS_PSIZE, msk);
    wb(1'b1, OFS_WRIDX, {1'b1, 28'h0, i});
  endtask

  // Flags: 8 miss, 4 refill, 2 invalid, 1 modified
  task automatic look(input logic [31:0] va, input tlbp_ref_t rt, input logic pcr,
                      input logic [3:0] fl, input logic [31:0] pa);
    tlbp_pipe_model_i.lookup(va, rt, pcr, rs);
    chk({28'h0, rs.miss, rs.refill, rs.invalid, rs.modified}, {28'h0, fl});
    if (fl == 4'h0)
      chk(rs.pa, pa);
  endtask

  initial
  begin
    fails = 0;
    tests_run = 0;
    resetn_i = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    va0 = 32'h1234_5800;
    va1 = 32'h0080_0000;
    va2 = 32'h4000_0000;
    gl = '{2'b00, 2'b01, 2'b11};
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    chk({31'h0, irq_o}, 32'h0);
    rdchk(OFS_FAULT, 32'h0);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    rdchk(8'h40, 32'h0);
    $display("test reset done");
    put(3'h0, va0, lo(0, 0, 20'h12345, 3'h3, 1, 1), lo(1, 0, 20'h0abcd, 3'h2, 0, 1), 32'h0);
    put(3'h1, va1, lo(0, 0, 20'h11111, 3'h0, 1, 0), lo(0, 1, 20'h54321, 3'h5, 1, 1), 32'h1800);
    put(3'h2, va2, 32'h0, lo(0, 0, 20'habcde, 3'h0, 1, 1), 32'h01ff_f800);
    look(va0 | 32'h123, TLBP_FETCH, 0, 4'h0, pa_of(20'h12345, 0, 10, va0 | 32'h123));
    chk({29'h0, rs.cache}, 32'h3);
    look(va0 | 32'h400, TLBP_LOAD, 0, 4'h2, 0);
    look(va0 | 32'h400, TLBP_LOAD, 1, 4'h0, pa_of(20'h0abcd, 0, 10, va0 | 32'h400));
    look(va0 | 32'h400, TLBP_STORE, 0, 4'h1, 0);
    look(va1, TLBP_FETCH, 0, 4'h2, 0);
    look(va1 | 32'h1000, TLBP_FETCH, 0, 4'h2, 0);
    chk({31'h0, irq_o}, 32'h0);
    rdchk(OFS_ISTAT, 32'h6);
    rdchk(OFS_ISTAT, 32'h0);
    foreach (gl[k])
    begin
      wb(1'b1, OFS_GRAIN, {30'h0, gl[k]});
      look(va1 | 32'h1abc, TLBP_STORE, 0, 4'h0,
           pa_of(20'h54321, gl[k], 12, va1 | 32'h1abc));
    end
    look(va2 | 32'h0123_4567, TLBP_LOAD, 0, 4'h0,
         pa_of(20'habcde, 2'b11, 24, va2 | 32'h0123_4567));
    $display("test translation done");
    wb(1'b1, OFS_GRAIN, 32'h1);
    wb(1'b1, OFS_LAYOUT, 32'h0000_0ff0);
    wb(1'b1, OFS_IMASK, 32'h1);
    wb(1'b1, OFS_HIGH, 32'h0000_005a);
    look(va0, TLBP_LOAD, 0, 4'hc, 0);
    rdchk(OFS_FAULT, va0);
    chk({31'h0, irq_o}, 32'h1);
    rdchk(OFS_HIGH, 32'h1234_505a);
    rdchk(OFS_PTRREG, 32'h0000_0120);
    rdchk(OFS_ISTAT, 32'h1);
    rdchk(OFS_ISTAT, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'b1, OFS_CTRL, 32'h1);
    look(va0, TLBP_FETCH, 0, 4'h8, 0);
    rdchk(OFS_ISTAT, 32'h0);
    $display("test refill done");
    wb(1'b1, OFS_HIGH, 32'h0);
    wb(1'b1, OFS_IMASK, 32'h6);
    rdchk(OFS_IMASK, 32'h6);
    look(va1, TLBP_FETCH, 0, 4'h2, 0);
    chk({31'h0, irq_o}, 32'h1);
    rdchk(OFS_ISTAT, 32'h2);
    $display("test mask done");
    test_done();
  end
endmodule // tlb_translation_protection_tb
